// File: pkg/vendor_status_pkg.sv
package vendor_status_pkg;

  localparam logic [7:0] cmd_vendor_fault_status = 8'h80;
  localparam logic [7:0] page_chan_a             = 8'h00;
  localparam logic [7:0] page_chan_b             = 8'h01;
  localparam logic [7:0] page_all                = 8'hFF;

  localparam int bit_power_stage_fault = 7;
  localparam int bit_sense_pin_open    = 6;
  localparam int bit_phase_clamp       = 5;
  localparam int bit_temp_sense_level  = 4;
  localparam int bit_voltage_code_rst  = 3;
  localparam int bit_share_fault       = 0;

  // writable, latched bits; 2 and 1 stay reserved
  localparam logic [7:0] mask_chan_a  = 8'hF9;
  localparam logic [7:0] mask_chan_b  = 8'hF1;
  localparam logic [7:0] reset_status = 8'h00;

  localparam int          phase_count = 6;
  localparam logic [3:0]  max_phases  = 4'h6;
  localparam logic [2:0]  share_cycles = 3'h7;

  typedef struct packed {
    logic       power_stage_fault;
    logic       sense_pin_open;
    logic       temp_sense_high;
    logic       voltage_code_reset;
    logic       imbalance_tick;
    logic [5:0] imbalance;
  } chan_events_s;

endpackage

// File: src/share_fault_detect.sv
`timescale 1ns/1ps
module share_fault_detect
  import vendor_status_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   tick,
  input  wire logic [phase_count-1:0] imbalance,
  output logic                        fault,
  output logic [phase_count-1:0]      readback
);

  typedef struct packed {
    logic [2:0]             run;
    logic                   fault;
    logic [phase_count-1:0] readback;
  } state_s;

  state_s state;
  state_s next_state;

  always_comb begin
    next_state       = state;
    next_state.fault = 1'b0;
    if (tick) begin
      next_state.readback = imbalance;
      if (imbalance == '0) begin
        next_state.run = 3'h0;
      end else if (state.run >= share_cycles - 3'h1) begin
        // seven consecutive detection cycles with any phase imbalanced;
        // saturate rather than wrap, so a lasting imbalance keeps firing
        next_state.run   = share_cycles;
        next_state.fault = 1'b1;
      end else begin
        next_state.run = state.run + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign fault    = state.fault;
  assign readback = state.readback;

endmodule // share_fault_detect

// File: src/vendor_fault_status.sv
`timescale 1ns/1ps
// Overview of operation
// - a read of command 80h returns one byte of vendor fault flags.
// - served only through read-byte and write-byte transactions.
// - page 00h selects channel A, page 01h selects channel B.
// - page FFh reads return the channel A contents.
// - bit 7 latches on a power-stage fault report.
// - bit 6 latches when the output sense pin was open at power-up.
// - phase count above hardware maximum sets bit 5 and is clamped.
// - bit 4 latches when temperature sense is 150 mV or more pre-start.
// - bit 3 marks a voltage-code reset, channel A only.
// - bit 0 sets after seven consecutive imbalance detection cycles.
// - per-phase imbalance is readable in a separate register.
// - writing one to a supported bit clears that flag.
module vendor_fault_status
  import vendor_status_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [7:0]   page,
  input  wire logic [7:0]   command,
  input  wire logic         read_byte,
  input  wire logic         write_byte,
  input  wire logic [7:0]   write_data,
  output logic [7:0]        read_data,
  output logic              read_valid,
  input  wire chan_events_s events_a,
  input  wire chan_events_s events_b,
  input  wire logic [3:0]   phases_req_a,
  input  wire logic [3:0]   phases_req_b,
  output logic [3:0]        phases_op_a,
  output logic [3:0]        phases_op_b,
  output logic [5:0]        imbalance_readback_a,
  output logic [5:0]        imbalance_readback_b
);

  typedef struct packed {
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] read_data;
    logic       read_valid;
    logic [3:0] phases_a;
    logic [3:0] phases_b;
  } state_s;

  state_s state;
  state_s next_state;

  logic       share_a;
  logic       share_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic       hit;
  logic       clamp_a;
  logic       clamp_b;
  logic       rd_hit;
  logic       wr_hit;
  logic       sel_a;
  logic       sel_b;
  logic       page_known;
  logic [7:0] read_mux;
  logic [7:0] next_status_a;
  logic [7:0] next_status_b;
  logic [3:0] next_phases_a;
  logic [3:0] next_phases_b;

  chan_events_s           chan_events [2];
  logic [1:0]             share;
  logic [phase_count-1:0] chan_readback [2];

  assign chan_events[0] = events_a;
  assign chan_events[1] = events_b;

  // one imbalance run counter per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_share
    share_fault_detect u_share (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .tick      (chan_events[ch].imbalance_tick),
      .imbalance (chan_events[ch].imbalance),
      .fault     (share[ch]),
      .readback  (chan_readback[ch])
    );
  end

  assign share_a              = share[0];
  assign share_b              = share[1];
  assign imbalance_readback_a = chan_readback[0];
  assign imbalance_readback_b = chan_readback[1];

  // only byte transactions on this command are decoded
  assign hit        = (command == cmd_vendor_fault_status);
  assign rd_hit     = read_byte && hit;
  assign wr_hit     = write_byte && hit;
  assign clamp_a    = phases_req_a > max_phases;
  assign clamp_b    = phases_req_b > max_phases;

  // FFh page writes both channels, as for other paged status
  assign sel_a      = (page == page_chan_a) || (page == page_all);
  assign sel_b      = (page == page_chan_b) || (page == page_all);
  assign page_known = sel_a || sel_b;

  always_comb begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[bit_power_stage_fault] = events_a.power_stage_fault;
    set_b[bit_power_stage_fault] = events_b.power_stage_fault;
    set_a[bit_sense_pin_open]    = events_a.sense_pin_open;
    set_b[bit_sense_pin_open]    = events_b.sense_pin_open;
    set_a[bit_phase_clamp]       = clamp_a;
    set_b[bit_phase_clamp]       = clamp_b;
    set_a[bit_temp_sense_level]  = events_a.temp_sense_high;
    set_b[bit_temp_sense_level]  = events_b.temp_sense_high;
    set_a[bit_voltage_code_rst]  = events_a.voltage_code_reset;
    set_a[bit_share_fault]       = share_a;
    set_b[bit_share_fault]       = share_b;
  end

  // a zero in the mask leaves its flag alone
  always_comb begin
    clr_a = 8'h00;
    clr_b = 8'h00;
    if (wr_hit && sel_a) begin
      clr_a = write_data;
    end
    if (wr_hit && sel_b) begin
      clr_b = write_data;
    end
  end

  // set wins over a clear in the same cycle, so a fault that is
  // still present is never lost to a host clear
  always_comb begin
    next_status_a = ((state.status_a & ~clr_a) | set_a)
                    & mask_chan_a;
    next_status_b = ((state.status_b & ~clr_b) | set_b)
                    & mask_chan_b;
  end

  // the clamp is applied every cycle, so its warning re-latches
  // for as long as the request stays above the hardware maximum
  always_comb begin
    next_phases_a = phases_req_a;
    next_phases_b = phases_req_b;
    if (clamp_a) begin
      next_phases_a = max_phases;
    end
    if (clamp_b) begin
      next_phases_b = max_phases;
    end
  end

  // unknown pages read as zero rather than alias a channel
  always_comb begin
    read_mux = 8'h00;
    if (page_known) begin
      unique case (page)
        page_chan_b: read_mux = state.status_b;
        page_chan_a: read_mux = state.status_a;
        page_all:    read_mux = state.status_a;
        default:     read_mux = 8'h00;
      endcase
    end
  end

  // read data holds until the next hit read
  always_comb begin
    next_state            = state;
    next_state.status_a   = next_status_a;
    next_state.status_b   = next_status_b;
    next_state.phases_a   = next_phases_a;
    next_state.phases_b   = next_phases_b;
    next_state.read_valid = rd_hit;
    if (rd_hit) begin
      next_state.read_data = read_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state.status_a   <= reset_status;
      state.status_b   <= reset_status;
      state.read_data  <= 8'h00;
      state.read_valid <= 1'b0;
      state.phases_a   <= 4'h0;
      state.phases_b   <= 4'h0;
    end else begin
      state <= next_state;
    end
  end

  assign read_data   = state.read_data;
  assign read_valid  = state.read_valid;
  assign phases_op_a = state.phases_a;
  assign phases_op_b = state.phases_b;

endmodule // vendor_fault_status

// File: bench/vendor_fault_status_monitor.sv
`timescale 1ns/1ps
module vendor_fault_status_monitor
  import vendor_status_pkg::*;
(
  input logic clk_sys,
  input logic reset,
  input logic [7:0] page,
  input logic [7:0] command,
  input logic read_byte,
  input logic write_byte,
  input logic [7:0] write_data,
  input logic [7:0] read_data,
  input logic read_valid,
  input chan_events_s events_a,
  input chan_events_s events_b,
  input logic [3:0] phases_req_a,
  input logic [3:0] phases_req_b,
  input logic [3:0] phases_op_a,
  input logic [3:0] phases_op_b,
  input logic [5:0] imbalance_readback_a,
  input logic [5:0] imbalance_readback_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire hit = read_byte && command == cmd_vendor_fault_status;
  chk_read_answer: assert property (hit |=> read_valid)
    else $error("read unanswered");
  chk_no_stray: assert property (!hit |=> !read_valid)
    else $error("stray answer");
  chk_reserved_zero: assert property (read_valid |-> !read_data[2:1])
    else $error("reserved set");
  chk_bad_page: assert property
    (hit && !(page inside {8'h00, 8'h01, 8'hFF}) |=> read_data == 8'h00)
    else $error("bad page data");
  chk_chan_b_bit3: assert property
    (hit && page == page_chan_b |=> !read_data[3]) else $error("b bit3");
  chk_clamp_a: assert property (!$past(reset) |-> phases_op_a ==
    ($past(phases_req_a) > max_phases ? max_phases : $past(phases_req_a)))
    else $error("clamp wrong");
  chk_fault_seen: assert property
    ($past(events_a.power_stage_fault) && hit && page == page_chan_a
     |=> read_data[7]) else $error("fault lost");
  chk_readback_b: assert property (events_b.imbalance_tick |=>
    imbalance_readback_b == $past(events_b.imbalance)) else $error("rdbk");
  cover property (hit && page == page_all);
  cover property (write_byte);
  cover property (events_b.imbalance_tick);
  cover property (read_valid && read_data[0]);
endmodule // vendor_fault_status_monitor
bind vendor_fault_status vendor_fault_status_monitor u_mon (
  .clk_sys              (clk_sys),
  .reset                (reset),
  .page                 (page),
  .command              (command),
  .read_byte            (read_byte),
  .write_byte           (write_byte),
  .write_data           (write_data),
  .read_data            (read_data),
  .read_valid           (read_valid),
  .events_a             (events_a),
  .events_b             (events_b),
  .phases_req_a         (phases_req_a),
  .phases_req_b         (phases_req_b),
  .phases_op_a          (phases_op_a),
  .phases_op_b          (phases_op_b),
  .imbalance_readback_a (imbalance_readback_a),
  .imbalance_readback_b (imbalance_readback_b)
);

// File: bench/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model
  import vendor_status_pkg::*;
(
  input logic clk_sys,
  output logic [7:0] page = 8'h00,
  output logic [7:0] command = 8'h00,
  output logic read_byte = 1'b0,
  output logic write_byte = 1'b0,
  output logic [7:0] write_data = 8'h00,
  input logic [7:0] read_data,
  input logic read_valid
);
  // single byte each way, paged by level
  task automatic rd(input  logic [7:0] pg,
                    input  logic [7:0] cmd,
                    output logic [7:0] d,
                    output logic       ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk_sys);
    page <= pg;
    command <= cmd;
    read_byte <= 1'b1;
    @(posedge clk_sys);
    read_byte <= 1'b0;
    // answer is a one-cycle registered pulse; bounded wait for it
    for (int i = 0; i < 3 && !ok; i++) begin
      @(posedge clk_sys);
      if (read_valid === 1'b1) begin
        ok = 1'b1;
        d  = read_data;
      end
    end
  endtask
  task automatic wr(input logic [7:0] pg,
                    input logic [7:0] cmd,
                    input logic [7:0] d);
    @(posedge clk_sys);
    page <= pg;
    command <= cmd;
    write_data <= d;
    write_byte <= 1'b1;
    @(posedge clk_sys);
    write_byte <= 1'b0;
    write_data <= ~d;
  endtask
endmodule // pmbus_host_model

// File: bench/mfr_status_flag_register_tb.sv
`timescale 1ns/1ps
module mfr_status_flag_register_tb import vendor_status_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] page, command, write_data, read_data, d;
  logic read_byte, write_byte, read_valid;
  chan_events_s events_a = '0, events_b = '0;
  logic [3:0] phases_req_a = 4'h8, phases_req_b = 4'h4;
  logic [3:0] phases_op_a, phases_op_b;
  logic [5:0] imbalance_readback_a, imbalance_readback_b;
  int errors = 0, total_checks = 0;
  logic ok;
  // any command code other than this register's
  localparam logic [7:0] cmd_other = 8'h7D;
  always #25 clk_sys = ~clk_sys;
  vendor_fault_status u_dut (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .page                 (page),
    .command              (command),
    .read_byte            (read_byte),
    .write_byte           (write_byte),
    .write_data           (write_data),
    .read_data            (read_data),
    .read_valid           (read_valid),
    .events_a             (events_a),
    .events_b             (events_b),
    .phases_req_a         (phases_req_a),
    .phases_req_b         (phases_req_b),
    .phases_op_a          (phases_op_a),
    .phases_op_b          (phases_op_b),
    .imbalance_readback_a (imbalance_readback_a),
    .imbalance_readback_b (imbalance_readback_b)
  );
  pmbus_host_model u_host (
    .clk_sys    (clk_sys),
    .page       (page),
    .command    (command),
    .read_byte  (read_byte),
    .write_byte (write_byte),
    .write_data (write_data),
    .read_data  (read_data),
    .read_valid (read_valid)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] pg, input logic [7:0] exp);
    u_host.rd(pg, cmd_vendor_fault_status, d, ok);
    if (ok !== 1'b1) begin
      chk({7'h00, ok}, 8'h01);
      end_sim;
    end else begin
      chk(d, exp);
    end
  endtask
  task automatic wc(input logic [7:0] pg, input logic [7:0] v);
    u_host.wr(pg, cmd_vendor_fault_status, v);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      events_b.imbalance_tick <= 1'b1;
      events_b.imbalance <= 6'h05;
      @(posedge clk_sys);
      events_b.imbalance_tick <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rc(page_chan_a, 8'h20);
    rc(page_chan_b, 8'h00);
    chk({4'h0, phases_op_b}, 8'h04);
    @(posedge clk_sys);
    events_a <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 6'h00};
    events_b <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 6'h00};
    @(posedge clk_sys);
    events_a <= '0;
    events_b <= '0;
    rc(page_chan_a, 8'hF8);
    rc(page_all, 8'hF8);
    rc(page_chan_b, 8'hD0);
    rc(8'h02, 8'h00);
    chk({4'h0, phases_op_a}, 8'h06);
    // a foreign command neither answers nor clears
    u_host.rd(page_chan_a, cmd_other, d, ok);
    chk({7'h00, ok}, 8'h00);
    u_host.wr(page_chan_a, cmd_other, 8'hFF);
    rc(page_chan_a, 8'hF8);
    wc(page_chan_a, 8'h00);
    rc(page_chan_a, 8'hF8);
    wc(page_chan_a, 8'hFF);
    rc(page_chan_a, 8'h20);
    phases_req_a <= 4'h5;
    wc(page_chan_a, 8'h20);
    rc(page_chan_a, 8'h00);
    // a fault still present while it is cleared must survive
    events_a.power_stage_fault <= 1'b1;
    wc(page_chan_a, 8'h80);
    rc(page_chan_a, 8'h80);
    events_a.power_stage_fault <= 1'b0;
    wc(page_chan_a, 8'h80);
    rc(page_chan_a, 8'h00);
    events_a.sense_pin_open <= 1'b1;
    @(posedge clk_sys);
    events_a.sense_pin_open <= 1'b0;
    rc(page_chan_a, 8'h40);
    wc(page_all, 8'hFF);
    rc(page_chan_a, 8'h00);
    rc(page_chan_b, 8'h00);
    events_a.imbalance <= 6'h2A;
    events_a.imbalance_tick <= 1'b1;
    @(posedge clk_sys);
    events_a.imbalance_tick <= 1'b0;
    events_a.imbalance <= 6'h00;
    @(posedge clk_sys);
    chk({2'h0, imbalance_readback_a}, 8'h2A);
    ticks(6);
    rc(page_chan_b, 8'h00);
    ticks(1);
    rc(page_chan_b, 8'h01);
    chk({2'h0, imbalance_readback_b}, 8'h05);
    wc(page_chan_b, 8'hFF);
    rc(page_chan_b, 8'h00);
    ticks(1);
    rc(page_chan_b, 8'h01);
    end_sim;
  end
endmodule // mfr_status_flag_register_tb
